// [dmit_pkg.sv]
package dmit_pkg;

  // register map of the timer pair
  localparam logic [7:0] DMIT_CTRL_A_ADDR = 8'he6;
  localparam logic [7:0] DMIT_CTRL_B_ADDR = 8'he7;
  localparam logic [7:0] DMIT_REF_A_ADDR = 8'he8;
  localparam logic [7:0] DMIT_REF_B_ADDR = 8'he9;
  localparam logic [7:0] DMIT_CNT_A_ADDR = 8'hea;
  localparam logic [7:0] DMIT_CNT_B_ADDR = 8'heb;

  // control register fields
  localparam int DMIT_MODE_BIT = 7;
  localparam int DMIT_SEL_HI = 6;
  localparam int DMIT_SEL_LO = 4;
  localparam int DMIT_CLEAR_BIT = 3;
  localparam int DMIT_RUN_BIT = 2;
  localparam int DMIT_IE_BIT = 1;
  localparam int DMIT_PEND_BIT = 0;
  localparam logic [7:0] DMIT_CTRL_RESET = 8'h00;
  localparam logic [7:0] DMIT_CTRL_B_MASK = 8'h77;
  localparam logic [7:0] DMIT_BYTE_ZERO = 8'h00;

  // count clock select codes
  localparam logic [2:0] DMIT_SEL_DIV512 = 3'h0;
  localparam logic [2:0] DMIT_SEL_DIV256 = 3'h1;
  localparam logic [2:0] DMIT_SEL_DIV64 = 3'h2;
  localparam logic [2:0] DMIT_SEL_DIV8 = 3'h3;
  localparam logic [2:0] DMIT_SEL_DIV1 = 3'h4;
  localparam logic [2:0] DMIT_SEL_SUB = 3'h5;

  // interrupt vectors, both at level zero
  localparam logic [7:0] DMIT_VEC_FIRST = 8'hf0;
  localparam logic [7:0] DMIT_VEC_SECOND = 8'hf2;

  // prescaler taps: divide by 512, 256, 64, 8 as low-bit widths
  localparam int DMIT_DIV_WIDTH = 9;
  localparam int DMIT_TAPS = 4;
  localparam int DMIT_TAP_BITS [DMIT_TAPS] = '{9, 8, 6, 3};

endpackage

// [dmit_prescaler.sv]
`timescale 1ns/10ps
module dmit_prescaler (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // one-cycle enables: [0] /512, [1] /256, [2] /64, [3] /8
  output logic [dmit_pkg::DMIT_TAPS-1:0] tick
);

  logic [dmit_pkg::DMIT_DIV_WIDTH-1:0] div_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  for (genvar i = 0; i < dmit_pkg::DMIT_TAPS; i++) begin : gTap
    always_ff @(posedge clock) begin
      if (rst) begin
        tick[i] <= 1'b0;
      end else begin
        tick[i] <= &div_q[dmit_pkg::DMIT_TAP_BITS[i]-1:0];
      end
    end
  end

endmodule // dmit_prescaler

// [dmit_timer.sv]
`timescale 1ns/10ps
module dmit_timer (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // count clock sources
  input wire logic subClock,
  input wire logic externalCountClock,
  // interrupt requests
  output logic firstMatchRequest,
  output logic secondMatchRequest,
  output logic irqRequest,
  output logic [7:0] irqVector,
  // match pins
  output logic firstMatchOut,
  output logic secondMatchOut
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrlA_q, ctrlB_q, refA_q, refB_q, cntA_q, cntB_q;
  logic subPrev_q, extPrev_q;
  logic [dmit_pkg::DMIT_TAPS-1:0] divTick;
  logic subRise, extRise, tickA, tickB;
  logic wideMode, runA, runB, wrCtrlA, wrCtrlB, clrA, clrB;
  logic matchWide, matchA, matchB;

  dmit_prescaler uPrescaler (
    .clock(clock),
    .rst(rst),
    .tick(divTick)
  );

  // sources are synchronous, so a rising level seen here is one count
  always_ff @(posedge clock) begin
    if (rst) begin
      subPrev_q <= 1'b0;
      extPrev_q <= 1'b0;
    end else begin
      subPrev_q <= subClock;
      extPrev_q <= externalCountClock;
    end
  end

  assign subRise = subClock & ~subPrev_q;
  assign extRise = externalCountClock & ~extPrev_q;

  ////////////////////////////////////////////////////////////////////////////
  // count clock selection

  always_comb begin
    case (ctrlA_q[dmit_pkg::DMIT_SEL_HI:dmit_pkg::DMIT_SEL_LO])
      dmit_pkg::DMIT_SEL_DIV512: tickA = divTick[0];
      dmit_pkg::DMIT_SEL_DIV256: tickA = divTick[1];
      dmit_pkg::DMIT_SEL_DIV64: tickA = divTick[2];
      dmit_pkg::DMIT_SEL_DIV8: tickA = divTick[3];
      dmit_pkg::DMIT_SEL_DIV1: tickA = 1'b1;
      dmit_pkg::DMIT_SEL_SUB: tickA = subRise;
      default: tickA = extRise;
    endcase
  end

  // timer B has no undivided or external choice; upper codes all mean sub clock
  always_comb begin
    case (ctrlB_q[dmit_pkg::DMIT_SEL_HI:dmit_pkg::DMIT_SEL_LO])
      dmit_pkg::DMIT_SEL_DIV512: tickB = divTick[0];
      dmit_pkg::DMIT_SEL_DIV256: tickB = divTick[1];
      dmit_pkg::DMIT_SEL_DIV64: tickB = divTick[2];
      dmit_pkg::DMIT_SEL_DIV8: tickB = divTick[3];
      default: tickB = subRise;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  assign wideMode = ctrlA_q[dmit_pkg::DMIT_MODE_BIT];
  assign runA = ctrlA_q[dmit_pkg::DMIT_RUN_BIT];
  assign runB = ctrlB_q[dmit_pkg::DMIT_RUN_BIT];
  assign wrCtrlA = regWrite && (regAddr == dmit_pkg::DMIT_CTRL_A_ADDR);
  assign wrCtrlB = regWrite && (regAddr == dmit_pkg::DMIT_CTRL_B_ADDR);
  assign clrA = wrCtrlA && regWdata[dmit_pkg::DMIT_CLEAR_BIT];
  assign clrB = wrCtrlB && regWdata[dmit_pkg::DMIT_CLEAR_BIT];

  // clear bit is a strobe and never stored; a match in the same cycle as a
  // pending clear keeps the bit set so the event is not lost
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrlA_q <= dmit_pkg::DMIT_CTRL_RESET;
      ctrlB_q <= dmit_pkg::DMIT_CTRL_RESET;
    end else begin
      if (wrCtrlA) begin
        ctrlA_q <= regWdata & ~(8'h01 << dmit_pkg::DMIT_CLEAR_BIT);
      end
      if (wrCtrlB) begin
        ctrlB_q <= regWdata & dmit_pkg::DMIT_CTRL_B_MASK & ~(8'h01 << dmit_pkg::DMIT_CLEAR_BIT);
      end
      if (matchWide || matchA) begin
        ctrlA_q[dmit_pkg::DMIT_PEND_BIT] <= 1'b1;
      end
      if (matchB) begin
        ctrlB_q[dmit_pkg::DMIT_PEND_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      refA_q <= dmit_pkg::DMIT_BYTE_ZERO;
      refB_q <= dmit_pkg::DMIT_BYTE_ZERO;
    end else if (regWrite) begin
      if (regAddr == dmit_pkg::DMIT_REF_A_ADDR) begin
        refA_q <= regWdata;
      end else if (regAddr == dmit_pkg::DMIT_REF_B_ADDR) begin
        refB_q <= regWdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters and compare

  assign matchWide = wideMode && runA && tickA && !clrA
    && ({cntA_q, cntB_q} == {refA_q, refB_q});
  assign matchA = !wideMode && runA && tickA && !clrA && (cntA_q == refA_q);
  assign matchB = !wideMode && runB && tickB && !clrB && (cntB_q == refB_q);

  always_ff @(posedge clock) begin
    if (rst) begin
      cntA_q <= dmit_pkg::DMIT_BYTE_ZERO;
      cntB_q <= dmit_pkg::DMIT_BYTE_ZERO;
    end else if (wideMode) begin
      if (clrA || matchWide) begin
        {cntA_q, cntB_q} <= {dmit_pkg::DMIT_BYTE_ZERO, dmit_pkg::DMIT_BYTE_ZERO};
      end else if (runA && tickA) begin
        {cntA_q, cntB_q} <= {cntA_q, cntB_q} + 16'h0001;
      end
    end else begin
      if (clrA || matchA) begin
        cntA_q <= dmit_pkg::DMIT_BYTE_ZERO;
      end else if (runA && tickA) begin
        cntA_q <= cntA_q + 8'h01;
      end
      if (clrB || matchB) begin
        cntB_q <= dmit_pkg::DMIT_BYTE_ZERO;
      end else if (runB && tickB) begin
        cntB_q <= cntB_q + 8'h01;
      end
    end
  end

  // pins hold in 16-bit mode, where only the wide interrupt reports a match
  always_ff @(posedge clock) begin
    if (rst) begin
      firstMatchOut <= 1'b0;
      secondMatchOut <= 1'b0;
    end else begin
      if (matchA) begin
        firstMatchOut <= ~firstMatchOut;
      end
      if (matchB) begin
        secondMatchOut <= ~secondMatchOut;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts and read back

  assign firstMatchRequest = ctrlA_q[dmit_pkg::DMIT_PEND_BIT] && ctrlA_q[dmit_pkg::DMIT_IE_BIT];
  assign secondMatchRequest = !wideMode && ctrlB_q[dmit_pkg::DMIT_PEND_BIT]
    && ctrlB_q[dmit_pkg::DMIT_IE_BIT];
  assign irqRequest = firstMatchRequest || secondMatchRequest;

  // f0 outranks f2 when both are asking
  always_ff @(posedge clock) begin
    if (rst) begin
      irqVector <= dmit_pkg::DMIT_BYTE_ZERO;
    end else if (firstMatchRequest) begin
      irqVector <= dmit_pkg::DMIT_VEC_FIRST;
    end else if (secondMatchRequest) begin
      irqVector <= dmit_pkg::DMIT_VEC_SECOND;
    end else begin
      irqVector <= dmit_pkg::DMIT_BYTE_ZERO;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      regRdata <= dmit_pkg::DMIT_BYTE_ZERO;
    end else if (regRead) begin
      if (regAddr == dmit_pkg::DMIT_CTRL_A_ADDR) begin
        regRdata <= ctrlA_q;
      end else if (regAddr == dmit_pkg::DMIT_CTRL_B_ADDR) begin
        regRdata <= ctrlB_q;
      end else if (regAddr == dmit_pkg::DMIT_REF_A_ADDR) begin
        regRdata <= refA_q;
      end else if (regAddr == dmit_pkg::DMIT_REF_B_ADDR) begin
        regRdata <= refB_q;
      end else if (regAddr == dmit_pkg::DMIT_CNT_A_ADDR) begin
        regRdata <= cntA_q;
      end else if (regAddr == dmit_pkg::DMIT_CNT_B_ADDR) begin
        regRdata <= cntB_q;
      end else begin
        regRdata <= dmit_pkg::DMIT_BYTE_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_wideCount;
    @(posedge clock) disable iff (rst)
    wideMode && runA && tickA && !clrA && !matchWide
      |=> {cntA_q, cntB_q} == $past({cntA_q, cntB_q}) + 16'h0001;
  endproperty
  a_wideCount: assert property (p_wideCount) else $error("wide count did not step");

  property p_wideMatch;
    @(posedge clock) disable iff (rst)
    matchWide |=> ({cntA_q, cntB_q} == 16'h0000) && ctrlA_q[dmit_pkg::DMIT_PEND_BIT];
  endproperty
  a_wideMatch: assert property (p_wideMatch) else $error("wide match did not restart");

  property p_wideOrder;
    @(posedge clock) disable iff (rst)
    matchWide |-> (cntA_q == refA_q) && (cntB_q == refB_q);
  endproperty
  a_wideOrder: assert property (p_wideOrder) else $error("wide match bytes misordered");

  property p_byteMatchB;
    @(posedge clock) disable iff (rst)
    matchB && !clrA && !(runA && tickA) |=> (cntB_q == 8'h00) && $stable(cntA_q);
  endproperty
  a_byteMatchB: assert property (p_byteMatchB) else $error("timer B match disturbed A");

  property p_vectorB;
    @(posedge clock) disable iff (rst)
    secondMatchRequest && !firstMatchRequest |=> irqVector == dmit_pkg::DMIT_VEC_SECOND;
  endproperty
  a_vectorB: assert property (p_vectorB) else $error("timer B vector wrong");

  property p_pendHold;
    @(posedge clock) disable iff (rst)
    ctrlA_q[dmit_pkg::DMIT_PEND_BIT] && !(wrCtrlA && !regWdata[dmit_pkg::DMIT_PEND_BIT])
      |=> ctrlA_q[dmit_pkg::DMIT_PEND_BIT];
  endproperty
  a_pendHold: assert property (p_pendHold) else $error("pending bit lost");

  property p_resetA;
    @(posedge clock) disable iff (rst)
    $past(rst) |-> (ctrlA_q == dmit_pkg::DMIT_CTRL_RESET) && (ctrlB_q == dmit_pkg::DMIT_CTRL_RESET);
  endproperty
  a_resetA: assert property (p_resetA) else $error("control not cleared by reset");

  property p_clear;
    @(posedge clock) disable iff (rst)
    clrA && wideMode |=> {cntA_q, cntB_q} == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("counter clear ignored");

  property p_toggle;
    @(posedge clock) disable iff (rst)
    matchA |=> firstMatchOut != $past(firstMatchOut);
  endproperty
  a_toggle: assert property (p_toggle) else $error("match pin did not toggle");

endmodule // dmit_timer

// [dmit_timer_tb_top.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module dmit_timer_tb_top;
  logic clock, rst, regWrite, regRead, subClock, externalCountClock;
  logic [7:0] regAddr, regWdata, regRdata, irqVector, rA, rB;
  logic firstMatchRequest, secondMatchRequest, irqRequest, firstMatchOut, secondMatchOut, o1;
  int fails, checks, cycles, p;
  logic [2:0] sels [6] = '{dmit_pkg::DMIT_SEL_DIV512, dmit_pkg::DMIT_SEL_DIV256,
    dmit_pkg::DMIT_SEL_DIV64, dmit_pkg::DMIT_SEL_DIV8, dmit_pkg::DMIT_SEL_SUB, 3'h6};
  int facts [6] = '{512, 256, 64, 8, 2, 2};

  dmit_timer i_dmit_timer (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .subClock(subClock),
    .externalCountClock(externalCountClock), .firstMatchRequest(firstMatchRequest),
    .secondMatchRequest(secondMatchRequest), .irqRequest(irqRequest), .irqVector(irqVector),
    .firstMatchOut(firstMatchOut), .secondMatchOut(secondMatchOut));

  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // sub and external sources toggle each cycle: one rising level every two cycles
  always @(negedge clock) begin
    subClock <= ~subClock;
    externalCountClock <= ~externalCountClock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      end_of_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  function automatic int expPeriod(input int factor, input int refVal);
    return factor * (refVal + 1);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clock);
    regWrite = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRead = 1'b0;
    `CHK("register read", e, regRdata)
  endtask

  task automatic waitReq(input bit second, output int n);
    n = 0;
    while (((second ? secondMatchRequest : firstMatchRequest) !== 1'b1) && n < 6000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 6000) `CHK("request wait", 1'b1, 1'b0)
  endtask

  // match to match distance; the pending clear write costs two cycles
  task automatic period(input bit second, input logic [7:0] a, input logic [7:0] d,
                        output int per);
    int n;
    // a pending bit left from earlier matches would end the first wait at a stale time
    wr(a, d);
    waitReq(second, n);
    wr(a, d);
    waitReq(second, n);
    per = n + 2;
  endtask

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    subClock = 1'b0;
    externalCountClock = 1'b0;
    void'($urandom(22));
    repeat (20) @(negedge clock);
    rst = 1'b0;
    rd(dmit_pkg::DMIT_CTRL_A_ADDR, 8'h00);
    rd(dmit_pkg::DMIT_CTRL_B_ADDR, 8'h00);
    rd(8'hf0, 8'h00);
    `CHK("vector idle", 8'h00, irqVector)
    $display("test reset done");
    // wide mode, reference bytes combined upper then lower
    for (int i = 0; i < 2; i++) begin
      rA = 8'(i);
      rB = 8'($urandom_range(15, 2));
      wr(dmit_pkg::DMIT_REF_A_ADDR, rA);
      wr(dmit_pkg::DMIT_REF_B_ADDR, rB);
      wr(dmit_pkg::DMIT_CTRL_A_ADDR, 8'hce);
      period(0, dmit_pkg::DMIT_CTRL_A_ADDR, 8'hc6, p);
      `CHK("wide period", expPeriod(1, {rA, rB}), p)
      @(negedge clock);
      `CHK("wide vector", 8'hf0, irqVector)
      `CHK("irq line", 1'b1, irqRequest)
      `CHK("second request", 1'b0, secondMatchRequest)
      `CHK("wide pin", 1'b0, firstMatchOut)
      rd(dmit_pkg::DMIT_CTRL_A_ADDR, 8'hc7);
    end
    // stopped with clear: both count bytes read zero
    wr(dmit_pkg::DMIT_CTRL_A_ADDR, 8'hc8);
    rd(dmit_pkg::DMIT_CNT_A_ADDR, 8'h00);
    rd(dmit_pkg::DMIT_CNT_B_ADDR, 8'h00);
    $display("test wide done");
    // split mode: A on main clock, B on sub clock
    wr(dmit_pkg::DMIT_CTRL_A_ADDR, 8'h00);
    rA = 8'($urandom_range(9, 2));
    rB = 8'($urandom_range(9, 2));
    wr(dmit_pkg::DMIT_REF_A_ADDR, rA);
    wr(dmit_pkg::DMIT_REF_B_ADDR, rB);
    wr(dmit_pkg::DMIT_CTRL_A_ADDR, 8'h4e);
    wr(dmit_pkg::DMIT_CTRL_B_ADDR, 8'h4e);
    period(0, dmit_pkg::DMIT_CTRL_A_ADDR, 8'h46, p);
    `CHK("first period", expPeriod(1, rA), p)
    @(negedge clock);
    o1 = firstMatchOut;
    repeat (p) @(negedge clock);
    `CHK("first pin toggle", ~o1, firstMatchOut)
    wr(dmit_pkg::DMIT_CTRL_A_ADDR, 8'h00);
    period(1, dmit_pkg::DMIT_CTRL_B_ADDR, 8'h46, p);
    `CHK("second period", expPeriod(2, rB), p)
    @(negedge clock);
    o1 = secondMatchOut;
    `CHK("second vector", 8'hf2, irqVector)
    rd(dmit_pkg::DMIT_CTRL_B_ADDR, 8'h47);
    repeat (p - 2) @(negedge clock);
    `CHK("second pin toggle", ~o1, secondMatchOut)
    wr(dmit_pkg::DMIT_CTRL_B_ADDR, 8'h00);
    $display("test split done");
    // every divided, sub and external count clock choice of timer A
    for (int i = 0; i < 6; i++) begin
      rA = (i < 2) ? 8'($urandom_range(1, 0)) : 8'($urandom_range(5, 1));
      wr(dmit_pkg::DMIT_REF_A_ADDR, rA);
      wr(dmit_pkg::DMIT_CTRL_A_ADDR, {1'b0, sels[i], 4'he});
      period(0, dmit_pkg::DMIT_CTRL_A_ADDR, {1'b0, sels[i], 4'h6}, p);
      `CHK("clock select period", expPeriod(facts[i], rA), p)
    end
    $display("test clock select done");
    end_of_test();
  end
endmodule // dmit_timer_tb_top
